// [hw/rpcf_pkg.sv]
package rpcf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Register indices; each register takes one aligned 32-bit word
  localparam logic [7:0] KEY_IDX = 8'h00;
  localparam logic [7:0] FLAGS_IDX = 8'h01;
  localparam logic [7:0] KEY_ADDR = 8'h00;
  localparam logic [7:0] FLAGS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;
  localparam logic [7:0] GPIO_ADDR = 8'h10;

  // ****************************************************************
  // Field values and positions
  // ****************************************************************
  localparam logic [7:0] KEY_GPIO = 8'hD0;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam int FLAG_W = 6;
  localparam int POWER_ON_BIT = 0;
  localparam int INDEP_WDOG_BIT = 1;
  localparam int BAD_OPCODE_BIT = 2;
  localparam int DEBUG_LINK_BIT = 3;
  localparam int WIN_WDOG_BIT = 4;
  localparam int BROWNOUT_BIT = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h01;
  localparam logic [5:0] IRQ_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic GPIO_RESET = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_TIME_NS = 20000;
  // Least time: round up to whole cycles
  localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 9;
  localparam logic [8:0] PULSE_LOAD = 9'(PULSE_CYCLES);
  localparam logic [2:0] HOLDOFF_LOAD = 3'h4;

endpackage

// [hw/rpcf_sync3.sv]
module rpcf_sync3
  #(parameter logic RESET_VAL = 1'b1)
  (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic d,
  output logic q
  );

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ****************************************************************
  // Three stages; the output moves only when stages two and three agree
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= RESET_VAL;
    else if (s2_r == s3_r)
      q <= s3_r;
  end

endmodule

// [hw/rpcf_top.sv]
// Notes on behaviour
// - key 0xD0 makes pin push-pull output
// - key accepts one write after reset
// - any other key value stored as 0x00
// - key register index 0x00, resets 0x00
// - six cause flags at index 0x01
// - writing one clears a flag
// - power-on leaves status reading 0x01
// - bad opcode reset sets bit 2
// - power-on clears all flags but power-on
// - output mode ignores external pin reset
// - internal reset drives pin low 20 us in reset mode
module rpcf_top
  import rpcf_pkg::*;
  (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic brownout_req,
  input wire logic window_watchdog_req,
  input wire logic debug_link_req,
  input wire logic bad_opcode_req,
  input wire logic independent_watchdog_req,
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  output logic ext_reset_req,
  output logic reset_pulse,
  output logic irq
  );

  logic rd_pend_r, wr_pend_r, key_written_r, port_a_bit_one_r;
  logic pin_out_r, pin_oe_r, ext_req_r, pulse_r;
  logic pin_level, addr_take, wr_now, rd_now, gpio_mode, internal_req;
  logic [7:0] dp_addr_r, pin_function_key_r;
  logic [31:0] hrdata_r, rd_mux;
  logic [5:0] flags_r, flags_nxt, irq_stat_r, irq_stat_nxt, irq_mask_r;
  logic [5:0] set_vec, clr_vec, rdclr_vec;
  logic [8:0] pulse_cnt_r;
  logic [2:0] holdoff_r;
  logic [9:0] drive_len_r;

  // ****************************************************************
  // AHB-Lite slave: writes zero-wait, reads with one wait state
  // ****************************************************************
  // The read wait state lets a write just before a read land first
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_now = wr_pend_r;
  assign rd_now = rd_pend_r;
  assign hreadyout = !rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end
    else
    begin
      if (addr_take)
      begin
        rd_pend_r <= !hwrite;
        wr_pend_r <= hwrite;
        dp_addr_r <= haddr[7:0];
      end
      else
      begin
        rd_pend_r <= 1'b0;
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Only low address bits decode; the map aliases across the slot
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (dp_addr_r)
      KEY_ADDR: rd_mux[7:0] = pin_function_key_r;
      FLAGS_ADDR: rd_mux[5:0] = flags_r;
      IRQ_STAT_ADDR: rd_mux[5:0] = irq_stat_r;
      IRQ_MASK_ADDR: rd_mux[5:0] = irq_mask_r;
      GPIO_ADDR: rd_mux[0] = port_a_bit_one_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (rd_now)
      hrdata_r <= rd_mux;
  end

  // ****************************************************************
  // Pin function key, write once
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_function_key_r <= KEY_RESET;
      key_written_r <= 1'b0;
    end
    else if (wr_now && dp_addr_r == KEY_ADDR && !key_written_r)
    begin
      key_written_r <= 1'b1;
      pin_function_key_r <= (hwdata[7:0] == KEY_GPIO) ? KEY_GPIO : KEY_RESET;
    end
  end

  assign gpio_mode = (pin_function_key_r == KEY_GPIO);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_a_bit_one_r <= GPIO_RESET;
    else if (wr_now && dp_addr_r == GPIO_ADDR)
      port_a_bit_one_r <= hwdata[0];
  end

  // ****************************************************************
  // Cause flags
  // ****************************************************************
  always_comb
  begin
    set_vec = 6'h00;
    set_vec[BROWNOUT_BIT] = brownout_req;
    set_vec[WIN_WDOG_BIT] = window_watchdog_req;
    set_vec[DEBUG_LINK_BIT] = debug_link_req;
    set_vec[BAD_OPCODE_BIT] = bad_opcode_req;
    set_vec[INDEP_WDOG_BIT] = independent_watchdog_req;
    set_vec[POWER_ON_BIT] = 1'b0;
  end

  assign clr_vec = (wr_now && dp_addr_r == FLAGS_ADDR) ? hwdata[5:0] : 6'h00;
  assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

  // Power-on is hresetn itself; other sources only add flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  assign rdclr_vec = (rd_now && dp_addr_r == IRQ_STAT_ADDR) ? irq_stat_r : 6'h00;
  assign irq_stat_nxt = (irq_stat_r & ~rdclr_vec) | set_vec;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_r <= IRQ_RESET;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_r <= MASK_RESET;
    else if (wr_now && dp_addr_r == IRQ_MASK_ADDR)
      irq_mask_r <= hwdata[5:0];
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************************************
  // Reset pulse generator and pin drive
  // ****************************************************************
  assign internal_req = |set_vec;

  // A new request restarts the full stretch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pulse_cnt_r <= '0;
    else if (internal_req)
      pulse_cnt_r <= PULSE_LOAD;
    else if (pulse_cnt_r != '0)
      pulse_cnt_r <= pulse_cnt_r - 9'h001;
  end

  // Output mode is push-pull; reset mode only pulls low, never high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_oe_r <= 1'b0;
      pin_out_r <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      pulse_r <= (pulse_cnt_r != '0);
      if (gpio_mode)
      begin
        pin_oe_r <= 1'b1;
        pin_out_r <= port_a_bit_one_r;
      end
      else
      begin
        pin_oe_r <= (pulse_cnt_r != '0);
        pin_out_r <= 1'b0;
      end
    end
  end

  assign external_reset_pin_out = pin_out_r;
  assign external_reset_pin_oe = pin_oe_r;
  assign reset_pulse = pulse_r;

  // ****************************************************************
  // External reset detection
  // ****************************************************************
  rpcf_sync3 #(.RESET_VAL(1'b1)) u_pin_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(external_reset_pin_in),
    .q(pin_level)
  );

  // Our own low drive echoes back through the synchroniser; hold off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      holdoff_r <= '0;
    else if (pin_oe_r && !gpio_mode)
      holdoff_r <= HOLDOFF_LOAD;
    else if (holdoff_r != '0)
      holdoff_r <= holdoff_r - 3'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_req_r <= 1'b0;
    else
      ext_req_r <= !gpio_mode && !pin_level && !pin_oe_r && holdoff_r == '0;
  end

  assign ext_reset_req = ext_req_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drive_len_r <= '0;
    else if (pulse_r)
      drive_len_r <= (drive_len_r == 10'h3FF) ? drive_len_r : drive_len_r + 10'h001;
    else
      drive_len_r <= '0;
  end

  property p_key_legal;
    @(posedge hclk) disable iff (!hresetn)
    pin_function_key_r == KEY_GPIO || pin_function_key_r == KEY_RESET;
  endproperty
  a_key_legal: assert property (p_key_legal) else $error("key holds illegal value");

  property p_key_once;
    @(posedge hclk) disable iff (!hresetn)
    key_written_r |=> $stable(pin_function_key_r) && key_written_r;
  endproperty
  a_key_once: assert property (p_key_once) else $error("key changed after first write");

  property p_gpio_drive;
    @(posedge hclk) disable iff (!hresetn)
    gpio_mode |=> ##1 (external_reset_pin_oe && external_reset_pin_out == $past(port_a_bit_one_r));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("output mode not driving pin");
  // At the falling edge the counter still holds the length of the stretch, saturated at 0x3FF
  property p_pulse_min;
    @(posedge hclk) disable iff (!hresetn)
    $fell(pulse_r) |-> drive_len_r >= 10'(PULSE_CYCLES);
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset pulse too short");
  property p_pulse_low;
    @(posedge hclk) disable iff (!hresetn)
    (internal_req && !gpio_mode) ##1 !gpio_mode |=> external_reset_pin_oe && !external_reset_pin_out;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("pin not pulled low on request");

  property p_no_ext;
    @(posedge hclk) disable iff (!hresetn)
    gpio_mode |=> !ext_reset_req;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("external reset seen in output mode");

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
    bad_opcode_req |=> flags_r[BAD_OPCODE_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("bad opcode flag not set");

  property p_zero_keeps;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && dp_addr_r == FLAGS_ADDR && !hwdata[WIN_WDOG_BIT] && flags_r[WIN_WDOG_BIT])
      |=> flags_r[WIN_WDOG_BIT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared a flag");

  property p_one_clears;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && dp_addr_r == FLAGS_ADDR && hwdata[POWER_ON_BIT]) |=> !flags_r[POWER_ON_BIT];
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("one write did not clear flag");

  property p_read_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && dp_addr_r == FLAGS_ADDR && set_vec == 6'h00) |=> $stable(flags_r);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("flag read changed flags");

endmodule

// [tb/rpcf_partner.sv]
module rpcf_partner
  (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic pull_low,
  output logic pin
  );
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Pin level
  // ****************************************************************
  // Pull-up wins when nobody drives; an outside pull-down wins over all
  assign pin = pull_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
endmodule

// [tb/rpcf_top_tb.sv]
module rpcf_top_tb
  import rpcf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pull_low = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] req = 0;
  logic hreadyout, hresp, irq, pin_out, pin_oe, ext_req, rpulse, pin, key_done;
  logic [7:0] key_m, k8;
  logic [5:0] flags_m, irq_m, mask_m, v;
  int n_mismatch = 0, total_checks = 0, seed = 94307, i, cnt, low;
  rpcf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .brownout_req(req[4]),
    .window_watchdog_req(req[3]), .debug_link_req(req[2]), .bad_opcode_req(req[1]),
    .independent_watchdog_req(req[0]), .external_reset_pin_in(pin),
    .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
    .ext_reset_req(ext_req), .reset_pulse(rpulse), .irq(irq));
  rpcf_partner partner_u (.pin_oe(pin_oe), .pin_out(pin_out), .pull_low(pull_low), .pin(pin));
  initial
  begin
    forever #20 hclk = ~hclk;
  end
  // ****************************************************************
  // Report and compare
  // ****************************************************************
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk_reg(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chk_bit(input logic e, input logic g);
    chk_reg({31'h0, e}, {31'h0, g});
  endtask
  // ****************************************************************
  // Bus master
  // ****************************************************************
  // Looks at hready half a cycle ahead, where it is settled for the edge
  task wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    d = hrdata;
    chk_bit(1'b0, hresp);
    @(posedge hclk);
    if (n >= 50)
    begin
      n_mismatch++;
      wrap_up;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [4:0] rq);
    logic [31:0] dm;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(dm);
    htrans <= 2'b00;
    hwdata <= d;
    req <= rq;
    wait_rdy(rv);
    hsel <= 1'b0;
    req <= 5'h00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [4:0] rq);
    xfer(1'b1, a, d, rq);
    flags_m = flags_m | {rq, 1'b0};
    if (a == FLAGS_ADDR)
      flags_m = (flags_m & ~d[5:0]) | {rq, 1'b0};
    if (a == KEY_ADDR && !key_done)
      key_m = (d[7:0] == KEY_GPIO) ? KEY_GPIO : KEY_RESET;
    key_done = key_done | (a == KEY_ADDR);
    if (a == IRQ_MASK_ADDR)
      mask_m = d[5:0];
    irq_m = irq_m | {rq, 1'b0};
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 5'h00);
    chk_reg(e, rv);
    if (a == IRQ_STAT_ADDR)
      irq_m = 6'h00;
  endtask
  // ****************************************************************
  // Reset sources and pulse
  // ****************************************************************
  task rst;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    key_m = KEY_RESET;
    key_done = 0;
    flags_m = FLAGS_RESET;
    irq_m = IRQ_RESET;
    mask_m = MASK_RESET;
  endtask
  task pulse(input logic [4:0] rq);
    @(posedge hclk);
    req <= rq;
    @(posedge hclk);
    req <= 5'h00;
    flags_m = flags_m | {rq, 1'b0};
    irq_m = irq_m | {rq, 1'b0};
    @(negedge hclk);
  endtask
  task meas(input logic drive);
    cnt = 0;
    low = 0;
    for (i = 0; i < 10 && rpulse !== 1'b1; i++)
      @(negedge hclk);
    while (rpulse === 1'b1 && cnt < 2000)
    begin
      cnt++;
      low = low + int'(pin === 1'b0);
      @(negedge hclk);
    end
    if (i >= 10 || cnt >= 2000)
    begin
      n_mismatch++;
      wrap_up;
    end
    chk_bit(1'b1, cnt >= PULSE_CYCLES);
    chk_reg(drive ? cnt : 0, low);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst;
    rd(KEY_ADDR, 32'h0);
    rd(FLAGS_ADDR, 32'h1);
    rd(8'h14, 32'h0);
    pull_low <= 1'b1;
    for (i = 0; i < 20 && ext_req !== 1'b1; i++)
      @(negedge hclk);
    chk_bit(1'b1, ext_req);
    if (ext_req !== 1'b1)
      wrap_up;
    @(posedge hclk);
    pull_low <= 1'b0;
    repeat (10) @(negedge hclk);
    $display("test reset values done");
    for (int s = 0; s < 5; s++)
    begin
      wr(IRQ_MASK_ADDR, s[0] ? 32'h0 : 32'h3E, 5'h00);
      pulse(5'h01 << s);
      chk_bit(|(irq_m & mask_m), irq);
      meas(1'b1);
      rd(FLAGS_ADDR, {26'h0, flags_m});
      rd(IRQ_STAT_ADDR, {26'h0, irq_m});
      @(negedge hclk);
      chk_bit(1'b0, irq);
    end
    $display("test cause flags done");
    wr(FLAGS_ADDR, 32'h0, 5'h00);
    rd(FLAGS_ADDR, {26'h0, flags_m});
    v = 6'($random(seed));
    wr(FLAGS_ADDR, {26'h0, v}, 5'h00);
    rd(FLAGS_ADDR, {26'h0, flags_m});
    wr(FLAGS_ADDR, 32'h3F, 5'h02);
    rd(FLAGS_ADDR, {26'h0, flags_m});
    $display("test clear done");
    wr(KEY_ADDR, {24'h0, KEY_GPIO}, 5'h00);
    rd(KEY_ADDR, {24'h0, key_m});
    for (int g = 0; g < 3; g++)
    begin
      wr(GPIO_ADDR, g[0] ? 32'h0 : 32'h1, 5'h00);
      repeat (2) @(negedge hclk);
      chk_bit(~g[0], pin);
    end
    wr(KEY_ADDR, 32'h0, 5'h00);
    rd(KEY_ADDR, {24'h0, key_m});
    pull_low <= 1'b1;
    repeat (20) @(negedge hclk);
    chk_bit(1'b0, ext_req);
    @(posedge hclk);
    pull_low <= 1'b0;
    pulse(5'h10);
    meas(1'b0);
    $display("test output mode done");
    rst;
    rd(FLAGS_ADDR, 32'h1);
    k8 = 8'($random(seed));
    if (k8 == KEY_GPIO)
      k8 = 8'h5A;
    wr(KEY_ADDR, {24'h0, k8}, 5'h00);
    rd(KEY_ADDR, {24'h0, key_m});
    wr(KEY_ADDR, {24'h0, KEY_GPIO}, 5'h00);
    rd(KEY_ADDR, {24'h0, key_m});
    @(negedge hclk);
    chk_bit(1'b0, pin_oe);
    $display("test second reset done");
    wrap_up;
  end
endmodule
